/* File: inc/pin_wake_pkg.sv */
// shared constants, field layouts and types for the pin wakeup and external interrupt block
package pin_wake_pkg;

    // register byte addresses on the peripheral bus
    localparam logic [31:0] ADDR_PENDING = 32'h4000a814;
    localparam logic [31:0] ADDR_CFG_A = 32'h4000a860;
    localparam logic [31:0] ADDR_CFG_B = 32'h4000a864;
    localparam logic [31:0] ADDR_CFG_C = 32'h4000a868;
    localparam logic [31:0] ADDR_CFG_D = 32'h4000a86c;
    localparam logic [31:0] ADDR_WAKE_A = 32'h4000bc08;
    localparam logic [31:0] ADDR_WAKE_B = 32'h4000bc0c;
    localparam logic [31:0] ADDR_WAKE_C = 32'h4000bc10;
    localparam logic [31:0] ADDR_SEL_C = 32'h4000bc14;
    localparam logic [31:0] ADDR_SEL_D = 32'h4000bc18;
    localparam logic [31:0] ADDR_WAKE_FILT = 32'h4000bc1c;

    // field positions
    localparam int CFG_FILT_BIT = 8;
    localparam int CFG_MODE_LSB = 5;
    localparam int WFILT_PINS_BIT = 0;
    localparam int WFILT_SER1_BIT = 1;
    localparam int WFILT_SER2_BIT = 2;
    localparam int WFILT_CHAND_BIT = 3;

    // reset values
    localparam logic [4:0] SEL_C_RESET = 5'h0f;
    localparam logic [4:0] SEL_D_RESET = 5'h10;
    localparam logic [3:0] PENDING_RESET = 4'h0;

    // pin codes: port a 0x00.., port b 0x08.., port c 0x10..0x17
    localparam logic [4:0] SEL_LAST_PIN = 5'h17;
    localparam int SERIAL1_PIN = 10;
    localparam int SERIAL2_PIN = 2;
    // fixed pins of channels a and b, values are arbitrary
    localparam logic [4:0] CHAN_A_PIN_DEF = 5'h08;
    localparam logic [4:0] CHAN_B_PIN_DEF = 5'h09;

    // input filter settle time
    localparam int CLOCK_PERIOD_NS = 5;
    localparam int FILTER_TIME_NS = 100;
    localparam int FILTER_CYCLES = (FILTER_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // trigger modes
    typedef enum logic [2:0] {
        TRIG_OFF = 3'h0,
        TRIG_RISE = 3'h1,
        TRIG_FALL = 3'h2,
        TRIG_BOTH = 3'h3,
        TRIG_HIGH = 3'h4,
        TRIG_LOW = 3'h5
    } trig_mode_t;

    // one channel configuration word
    typedef struct packed {
        logic filt;
        logic [2:0] mode;
    } chan_cfg_t;

    // wakeup filter controls
    typedef struct packed {
        logic chanD;
        logic serialTwo;
        logic serialOne;
        logic pins;
    } wake_filt_t;

endpackage

/* File: logic/pin_wake_irq.sv */
// pin wakeup monitor and four external interrupt channels behind an apb slave
// Overview of operation
// - per-port 8-bit wakeup enable mask per pin
// - filter bit 0 filters all mask-selected wake pins
// - filter bit 1 filters serial one wake pin
// - filter bit 2 filters serial two wake pin
// - filter bit 3 filters channel d wake source
// - channels c, d select any of 24 pins
// - selector resets: c to 0x0f, d to 0x10
// - config bit 8 enables channel input filtering
// - mode 0 off, 1 rise, 2 fall, 3 both
// - mode 4 high level, 5 low level
// - pending flags a..d at bits 0..3
// - write one clears pending, zero keeps
// - four independent channels, separate config registers
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module pin_wake_irq
    import pin_wake_pkg::*;
#(
    parameter int FILT_CYCLES = FILTER_CYCLES,
    parameter logic [4:0] CHAN_A_PIN = CHAN_A_PIN_DEF,
    parameter logic [4:0] CHAN_B_PIN = CHAN_B_PIN_DEF
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output var logic [31:0] prdata,
    output var logic pready,
    output var logic pslverr,
    // package pins, asynchronous
    input wire logic [7:0] portAPins,
    input wire logic [7:0] portBPins,
    input wire logic [7:0] portCPins,
    // wake source enables from the power manager
    input wire logic serialOneWakeEn,
    input wire logic serialTwoWakeEn,
    input wire logic chanDWakeEn,
    // results
    output var logic [3:0] extIrq,
    output var logic wakeEvent
);

    localparam int CW = $clog2(FILT_CYCLES + 1);

    // refuse settings the logic cannot serve
    generate
        if (FILT_CYCLES < 1 || FILT_CYCLES > 4096)
        begin : g_bad_filt
            $error("filter length out of range");
        end
        if (CHAN_A_PIN > SEL_LAST_PIN || CHAN_B_PIN > SEL_LAST_PIN)
        begin : g_bad_pin
            $error("fixed channel pin out of range");
        end
    endgenerate

    // software-visible state
    logic [7:0] wakeMask [3]; // port_wake_enable_mask per port
    chan_cfg_t chanCfg [4]; // per channel mode and filter
    logic [4:0] selC; // channel c pin code
    logic [4:0] selD; // channel d pin code
    wake_filt_t wakeFilt; // wakeup filter controls

    // pin synchronisers, first stage read only by the second
    logic [23:0] pinMeta;
    logic [23:0] pinSync;
    // filtered pin levels
    logic [23:0] pinFilt;

    // per channel level and its previous value
    logic [3:0] chanLvl;
    logic [3:0] chanPrev;
    logic [3:0] chanTrig;
    logic [3:0] next_pending;

    // wake sources: 24 pins, serial one, serial two, channel d
    logic [26:0] wakeLvl;
    logic [26:0] wakePrev;
    logic [26:0] wakeEnable;

    // bus decode wires
    wire setupPhase = psel & ~penable;
    wire wrStrobe = psel & penable & pready & pwrite;
    wire hitPending = (paddr == ADDR_PENDING);
    wire hitCfgA = (paddr == ADDR_CFG_A);
    wire hitCfgB = (paddr == ADDR_CFG_B);
    wire hitCfgC = (paddr == ADDR_CFG_C);
    wire hitCfgD = (paddr == ADDR_CFG_D);
    wire hitWakeA = (paddr == ADDR_WAKE_A);
    wire hitWakeB = (paddr == ADDR_WAKE_B);
    wire hitWakeC = (paddr == ADDR_WAKE_C);
    wire hitSelC = (paddr == ADDR_SEL_C);
    wire hitSelD = (paddr == ADDR_SEL_D);
    wire hitFilt = (paddr == ADDR_WAKE_FILT);
    wire [3:0] hitCfg = {hitCfgD, hitCfgC, hitCfgB, hitCfgA};
    wire [2:0] hitWake = {hitWakeC, hitWakeB, hitWakeA};
    wire anyHit = hitPending | (|hitCfg) | (|hitWake) | hitSelC | hitSelD | hitFilt;

    // byte lane 0 and 1 write enables
    wire lane0 = wrStrobe & pstrb[0];
    wire lane1 = wrStrobe & pstrb[1];

    // one-to-clear mask from a write of the flag register
    wire [3:0] clearMask = (lane0 && hitPending) ? pwdata[3:0] : 4'h0;

    // pin codes per channel
    wire [4:0] chanSel [4];
    assign chanSel[0] = CHAN_A_PIN;
    assign chanSel[1] = CHAN_B_PIN;
    assign chanSel[2] = selC;
    assign chanSel[3] = selD;

    // read data selection
    logic [31:0] readMux;

    // synchronise every pin, two flops before any logic
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pinMeta <= 24'h000000;
            pinSync <= 24'h000000;
        end
        else
        begin
            pinMeta <= {portCPins, portBPins, portAPins};
            pinSync <= pinMeta;
        end
    end

    // glitch filter per pin: a new level is taken only after it
    // stays put for the whole filter time; shared by wake and irq
    // paths so a channel's filter costs no extra counters
    genvar gp;
    generate
        for (gp = 0; gp < 24; gp++)
        begin : g_filt
            logic [CW-1:0] stable;
            always_ff @(posedge clock or posedge rst)
            begin
                if (rst)
                begin
                    stable <= '0;
                    pinFilt[gp] <= 1'b0;
                end
                else if (pinSync[gp] == pinFilt[gp])
                begin
                    // level agrees, restart the count
                    stable <= '0;
                end
                else if (stable == CW'(FILT_CYCLES - 1))
                begin
                    // held long enough, accept it
                    stable <= '0;
                    pinFilt[gp] <= pinSync[gp];
                end
                else
                begin
                    stable <= stable + 1'b1;
                end
            end
        end
    endgenerate

    // channel input choice and trigger decode
    genvar gc;
    generate
        for (gc = 0; gc < 4; gc++)
        begin : g_chan
            // reserved codes select no pin and read low
            wire validSel = (chanSel[gc] <= SEL_LAST_PIN);
            wire [4:0] idx = validSel ? chanSel[gc] : 5'h00;
            wire rawLvl = validSel & pinSync[idx];
            wire filtLvl = validSel & pinFilt[idx];
            wire [2:0] mode = chanCfg[gc].mode;
            assign chanLvl[gc] = chanCfg[gc].filt ? filtLvl : rawLvl;
            wire rise = chanLvl[gc] & ~chanPrev[gc];
            wire fall = ~chanLvl[gc] & chanPrev[gc];
            // edge modes look at the change, level modes at the level
            assign chanTrig[gc] =
                (mode == TRIG_RISE) ? rise :
                (mode == TRIG_FALL) ? fall :
                (mode == TRIG_BOTH) ? (rise | fall) :
                (mode == TRIG_HIGH) ? chanLvl[gc] :
                (mode == TRIG_LOW) ? ~chanLvl[gc] :
                1'b0; // off and reserved modes never fire
        end
    endgenerate

    // set wins over a clear in the same cycle, so no event is lost;
    // a held level keeps the flag set through the clear
    assign next_pending = (extIrq & ~clearMask) | chanTrig;

    // previous channel levels for edge detection
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            chanPrev <= 4'h0;
        end
        else
        begin
            chanPrev <= chanLvl;
        end
    end

    // pending flags, which are also the interrupt lines
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            extIrq <= PENDING_RESET;
        end
        else
        begin
            extIrq <= next_pending;
        end
    end

    // wake source levels, each picks raw or filtered per its control
    assign wakeLvl[23:0] = wakeFilt.pins ? pinFilt : pinSync;
    assign wakeLvl[24] = wakeFilt.serialOne ? pinFilt[SERIAL1_PIN] : pinSync[SERIAL1_PIN];
    assign wakeLvl[25] = wakeFilt.serialTwo ? pinFilt[SERIAL2_PIN] : pinSync[SERIAL2_PIN];
    assign wakeLvl[26] = wakeFilt.chanD ? g_chan[3].filtLvl : g_chan[3].rawLvl;

    // only monitored pins and enabled sources may wake
    assign wakeEnable = {chanDWakeEn, serialTwoWakeEn, serialOneWakeEn,
                         wakeMask[2], wakeMask[1], wakeMask[0]};

    // wake on any change of an enabled source
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            wakePrev <= '0;
            wakeEvent <= 1'b0;
        end
        else
        begin
            wakePrev <= wakeLvl;
            wakeEvent <= |((wakeLvl ^ wakePrev) & wakeEnable);
        end
    end

    // channel configuration registers, one word each
    genvar gr;
    generate
        for (gr = 0; gr < 4; gr++)
        begin : g_cfg
            always_ff @(posedge clock or posedge rst)
            begin
                if (rst)
                begin
                    chanCfg[gr] <= '0;
                end
                else if (hitCfg[gr])
                begin
                    // each channel decodes only its own address
                    if (lane0)
                    begin
                        chanCfg[gr].mode <= pwdata[CFG_MODE_LSB +: 3];
                    end
                    if (lane1)
                    begin
                        chanCfg[gr].filt <= pwdata[CFG_FILT_BIT];
                    end
                end
            end
        end
        for (gr = 0; gr < 3; gr++)
        begin : g_wake
            always_ff @(posedge clock or posedge rst)
            begin
                if (rst)
                begin
                    wakeMask[gr] <= 8'h00;
                end
                else if (lane0 && hitWake[gr])
                begin
                    wakeMask[gr] <= pwdata[7:0];
                end
            end
        end
    endgenerate

    // pin selectors and wakeup filter controls
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            selC <= SEL_C_RESET;
            selD <= SEL_D_RESET;
            wakeFilt <= '0;
        end
        else if (lane0)
        begin
            if (hitSelC)
            begin
                selC <= pwdata[4:0];
            end
            if (hitSelD)
            begin
                selD <= pwdata[4:0];
            end
            if (hitFilt)
            begin
                wakeFilt <= pwdata[3:0];
            end
        end
    end

    // read data, unused bits read as zero
    always_comb
    begin
        readMux = 32'h00000000;
        if (hitPending)
        begin
            readMux[3:0] = extIrq;
        end
        for (int i = 0; i < 4; i++)
        begin
            if (hitCfg[i])
            begin
                readMux[CFG_FILT_BIT] = chanCfg[i].filt;
                readMux[CFG_MODE_LSB +: 3] = chanCfg[i].mode;
            end
        end
        for (int i = 0; i < 3; i++)
        begin
            if (hitWake[i])
            begin
                readMux[7:0] = wakeMask[i];
            end
        end
        if (hitSelC)
        begin
            readMux[4:0] = selC;
        end
        if (hitSelD)
        begin
            readMux[4:0] = selD;
        end
        if (hitFilt)
        begin
            readMux[3:0] = wakeFilt;
        end
    end

    // apb answer: ready in the first access cycle, data and error
    // captured at the setup edge so they come straight from flops;
    // a read of the flags shows them as of the setup edge
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= setupPhase;
            pslverr <= setupPhase & ~anyHit;
            if (setupPhase)
            begin
                // unmapped or write reads back zero
                prdata <= (anyHit && !pwrite) ? readMux : 32'h00000000;
            end
        end
    end

endmodule
`default_nettype wire

/* File: tb/pin_wake_irq_properties.sv */
// port-level checks for the pin wakeup and interrupt block
`timescale 1ns/100ps
`default_nettype none
module pin_wake_irq_properties
    import pin_wake_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // apb side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and results
    input wire logic [7:0] portAPins,
    input wire logic [7:0] portBPins,
    input wire logic [7:0] portCPins,
    input wire logic serialOneWakeEn,
    input wire logic serialTwoWakeEn,
    input wire logic chanDWakeEn,
    input wire logic [3:0] extIrq,
    input wire logic wakeEvent
);
    // clear request at the access edge; flags may only fall after one
    wire logic clrHit = psel && penable && pready && pwrite && paddr == ADDR_PENDING;
    wire logic [3:0] clrReq = (clrHit && pstrb[0]) ? pwdata[3:0] : 4'h0;
    // read setup cycle
    wire logic rdSetup = psel && !penable && !pwrite;
    wire logic cfgAddr = paddr inside {ADDR_CFG_A, ADDR_CFG_B, ADDR_CFG_C, ADDR_CFG_D};

    chk_ready_next: assert property (@(posedge clock) disable iff (rst)
        psel && !penable |=> pready) else $error("no ready after setup");
    chk_ready_once: assert property (@(posedge clock) disable iff (rst)
        pready |=> !pready) else $error("ready held too long");
    chk_err_zero: assert property (@(posedge clock) disable iff (rst)
        pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
    chk_flag_kept: assert property (@(posedge clock) disable iff (rst)
        ($past(extIrq) & ~extIrq & ~$past(clrReq) & ~$past(clrReq, 2)) == 4'h0)
        else $error("flag dropped without clear");
    chk_flag_read: assert property (@(posedge clock) disable iff (rst)
        rdSetup && paddr == ADDR_PENDING |=> prdata == {28'h0, $past(extIrq)})
        else $error("flag read differs from irq");
    chk_cfg_zero: assert property (@(posedge clock) disable iff (rst)
        rdSetup && cfgAddr |=> prdata[31:9] == 23'h0 && prdata[4:0] == 5'h0)
        else $error("config unused bits set");
    chk_sel_zero: assert property (@(posedge clock) disable iff (rst)
        rdSetup && (paddr == ADDR_SEL_C || paddr == ADDR_SEL_D) |=> prdata[31:5] == 27'h0)
        else $error("selector wider than five bits");
    chk_reset_quiet: assert property (@(posedge clock)
        rst |-> extIrq == 4'h0 && !wakeEvent && !pready) else $error("outputs active in reset");
endmodule
bind pin_wake_irq pin_wake_irq_properties chk (.clock, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .portAPins, .portBPins,
    .portCPins, .serialOneWakeEn, .serialTwoWakeEn, .chanDWakeEn, .extIrq, .wakeEvent);
`default_nettype wire

/* File: tb/pin_source.sv */
// model of the 24 package pins: code 0..7 port a, 8..15 port b, 16..23 port c
`timescale 1ns/100ps
`default_nettype none
module pin_source (
    // clock
    input wire logic clock,
    // pin levels, low at start
    output var logic [23:0] pins
);
    initial pins = 24'h0;
    // change one pin just after an edge
    task automatic drive(input int code, input logic lvl);
        @(posedge clock);
        pins[code] <= lvl;
    endtask
    // one-cycle pulse, shorter than a filter window of two or more cycles
    task automatic glitch(input int code);
        logic lvl;
        // level taken once: the first drive's update has not landed yet
        // when the second starts, so re-reading the pin would step it
        lvl = pins[code];
        drive(code, ~lvl);
        drive(code, lvl);
    endtask
endmodule
`default_nettype wire

/* File: tb/pin_wake_irq_tb.sv */
// self-checking bench for the pin wakeup and external interrupt block
`timescale 1ns/100ps
`default_nettype none
module pin_wake_irq_tb;
    import pin_wake_pkg::*;
    // stimulus and observed signals
    // reset starts unknown and is raised by an event at time zero
    logic clock = 1'b0, rst, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hf, extIrq;
    logic pready, pslverr, wakeEvent, er;
    logic serialOneWakeEn = 1'b0, serialTwoWakeEn = 1'b0, chanDWakeEn = 1'b0;
    logic [23:0] pinLvl;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    // register table: address, reset value, writable bits
    logic [31:0] ad [11] = '{ADDR_PENDING, ADDR_CFG_A, ADDR_CFG_B, ADDR_CFG_C, ADDR_CFG_D,
        ADDR_WAKE_A, ADDR_WAKE_B, ADDR_WAKE_C, ADDR_SEL_C, ADDR_SEL_D, ADDR_WAKE_FILT};
    logic [31:0] rv [11] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
        32'hf, 32'h10, 32'h0};
    logic [31:0] wm [11] = '{32'h0, 32'h1e0, 32'h1e0, 32'h1e0, 32'h1e0, 32'hff, 32'hff,
        32'hff, 32'h1f, 32'h1f, 32'hf};

    initial forever #2.5 clock = ~clock;

    // small filter so filtered paths stay short
    pin_wake_irq #(.FILT_CYCLES(2)) dut (.clock, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .portAPins(pinLvl[7:0]),
        .portBPins(pinLvl[15:8]), .portCPins(pinLvl[23:16]), .serialOneWakeEn,
        .serialTwoWakeEn, .chanDWakeEn, .extIrq, .wakeEvent);
    pin_source pins (.clock, .pins(pinLvl));

    // compare and count
    task automatic check(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one apb transfer; held until pready, result in rd and er
    task automatic apb(input logic wr, input logic [31:0] a, d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // reset values, writable bits, unmapped address
    task automatic t_regs;
        for (int i = 0; i < 11; i++)
        begin
            apb(1'b0, ad[i], 32'h0);
            check("reset value", rd, rv[i]);
            apb(1'b1, ad[i], 32'hffffff9f);
            apb(1'b0, ad[i], 32'h0);
            check("write mask", rd, 32'hffffff9f & wm[i]);
            apb(1'b1, ad[i], rv[i]);
        end
        apb(1'b0, ADDR_PENDING + 32'h4, 32'h0);
        check("unmapped", {rd[30:0], er}, 32'h1);
        $display("done regs");
    endtask
    // every trigger mode on channel a, pin code 8
    task automatic t_modes;
        logic [1:0] em [6] = '{2'b00, 2'b01, 2'b10, 2'b11, 2'b11, 2'b11};
        for (int m = 0; m < 6; m++)
        begin
            apb(1'b1, ADDR_CFG_A, 32'(m) << CFG_MODE_LSB);
            tick(8);
            apb(1'b1, ADDR_PENDING, 32'h1);
            pins.drive(CHAN_A_PIN_DEF, 1'b1);
            tick(8);
            apb(1'b1, ADDR_PENDING, 32'h0);
            check("after rise", 32'(extIrq), 32'(em[m][0]));
            apb(1'b1, ADDR_PENDING, 32'h1);
            pins.drive(CHAN_A_PIN_DEF, 1'b0);
            tick(8);
            check("after fall", 32'(extIrq), 32'(em[m][1]));
            apb(1'b1, ADDR_PENDING, 32'h1);
            tick(4);
            apb(1'b0, ADDR_PENDING, 32'h0);
            check("level again", rd, 32'(m == 5));
        end
        apb(1'b1, ADDR_CFG_A, 32'h0);
        $display("done modes");
    endtask
    // channel c on all 24 codes, channel d on its reset pin, b on its fixed pin
    task automatic t_route;
        logic [31:0] ex;
        apb(1'b1, ADDR_CFG_B, 32'h20);
        apb(1'b1, ADDR_CFG_C, 32'h20);
        apb(1'b1, ADDR_CFG_D, 32'h20);
        for (int c = 0; c < 24; c++)
        begin
            apb(1'b1, ADDR_SEL_C, 32'(c));
            tick(6);
            apb(1'b1, ADDR_PENDING, 32'hf);
            pins.drive(c, 1'b1);
            tick(8);
            // c always fires; d shares pin 16, b its own fixed pin
            ex = {28'h0, c == 16, 1'b1, c == CHAN_B_PIN_DEF, 1'b0};
            check("routing", 32'(extIrq), ex);
            pins.drive(c, 1'b0);
        end
        apb(1'b1, ADDR_CFG_B, 32'h0);
        apb(1'b1, ADDR_CFG_C, 32'h0);
        apb(1'b1, ADDR_CFG_D, 32'h0);
        $display("done route");
    endtask
    // short pulse with channel filter on, then off
    task automatic t_filter;
        for (int f = 1; f >= 0; f--)
        begin
            apb(1'b1, ADDR_CFG_A, 32'h20 | (32'(f) << CFG_FILT_BIT));
            tick(8);
            apb(1'b1, ADDR_PENDING, 32'hf);
            pins.glitch(CHAN_A_PIN_DEF);
            tick(10);
            check("pulse filter", 32'(extIrq), 32'(f == 0));
        end
        apb(1'b1, ADDR_CFG_A, 32'h0);
        apb(1'b1, ADDR_PENDING, 32'hf);
        $display("done filter");
    endtask
    // count wake pulses after a pin change or glitch
    task automatic probe(input int code, input logic gl, input int exp);
        int cnt;
        cnt = 0;
        if (gl)
            pins.glitch(code);
        else
            pins.drive(code, ~pinLvl[code]);
        repeat (12) @(posedge clock) cnt += (wakeEvent === 1'b1) ? 1 : 0;
        check("wake pulses", 32'(cnt), 32'(exp));
    endtask
    // each wake source with its own filter bit, others, and none
    task automatic t_wake;
        int src [4] = '{3, 10, 2, 16};
        apb(1'b1, ADDR_WAKE_A, 32'h8);
        probe(4, 1'b0, 0);
        for (int k = 0; k < 4; k++)
        begin
            serialOneWakeEn <= (k == 1);
            serialTwoWakeEn <= (k == 2);
            chanDWakeEn <= (k == 3);
            apb(1'b1, ADDR_WAKE_A, (k == 0) ? 32'h8 : 32'h0);
            apb(1'b1, ADDR_WAKE_FILT, 32'h0);
            probe(src[k], 1'b1, 2);
            apb(1'b1, ADDR_WAKE_FILT, ~(32'h1 << k) & 32'hf);
            probe(src[k], 1'b1, 2);
            apb(1'b1, ADDR_WAKE_FILT, 32'h1 << k);
            probe(src[k], 1'b1, 0);
            probe(src[k], 1'b0, 1);
        end
        $display("done wake");
    endtask

    // hang guard
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            close_out;
        end
    end

    initial
    begin
        // an x to 1 change wakes the asynchronous reset before the first edge
        rst <= 1'b1;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        t_regs;
        t_modes;
        t_route;
        t_filter;
        t_wake;
        close_out;
    end
endmodule
`default_nettype wire
